// file: hpmg_pkg.sv
// Package for the expansion header pin mux: constants, pin map, carrier and state types.
// Assumes a single 250 MHz clock; counts of cycles are derived here from the rates.
package hpmg_pkg;

    // ==========================================================
    // Rates and derived counts
    localparam int CLK_HZ       = 250_000_000;
    localparam int PWM_HZ       = 100;
    localparam int PWM_STEPS    = 100;
    localparam int POLL_HZ      = 50;
    localparam int ADC_HZ       = 11_000;
    localparam int PWM_STEP_CYC = CLK_HZ / (PWM_HZ * PWM_STEPS);
    localparam int POLL_CYC     = CLK_HZ / POLL_HZ;
    localparam int ADC_CYC      = CLK_HZ / ADC_HZ;

    // ==========================================================
    // Widths and field values
    localparam int NPIN  = 13;
    localparam int CW    = 23;
    localparam int ADC_W = 12;
    localparam int SUM_W = 32;
    localparam int CNT_W = 20;
    localparam int NUM_W = ADC_W + 4 + CNT_W;
    localparam int QUO_W = 16;
    localparam logic [6:0]       DUTY_FULL = 7'h64;
    localparam logic [6:0]       PH_LAST   = 7'h63;
    localparam logic [5:0]       DIV_LAST  = 6'h23;
    localparam logic [3:0]       AVG_PAD   = 4'h0;
    localparam logic [ADC_W-1:0] MIN_INIT  = 12'hfff;

    // ==========================================================
    // Pin map (index = header pin - 1)
    localparam int P_ADC0     = 4;
    localparam int P_PWR_CTL  = 8;
    localparam int P_RESTART  = 9;
    localparam int P_PWR_SNS  = 11;
    localparam logic [NPIN-1:0] SER_MASK = 13'h0003;
    localparam logic [NPIN-1:0] I2C_MASK = 13'h100c;
    localparam logic [NPIN-1:0] SPI_MASK = 13'h0bc0;
    localparam logic [NPIN-1:0] ADC_MASK = 13'h0030;
    localparam logic [NPIN-1:0] ATX_MASK = 13'h0300;

    // ==========================================================
    // Values after reset
    localparam logic SER_EN_RST = 1'h1;
    localparam logic I2C_EN_RST = 1'h0;
    localparam logic SPI_EN_RST = 1'h0;
    localparam logic ATX_EN_RST = 1'h1;

    typedef enum logic [2:0] {
        DRV_HIZ         = 3'b000,
        DRV_PULL_UP     = 3'b001,
        DRV_PULL_DOWN   = 3'b010,
        DRV_STRONG_UP   = 3'b011,
        DRV_STRONG_DOWN = 3'b100,
        DRV_STRONG      = 3'b101
    } hpmg_drv_t;
    localparam hpmg_drv_t DRV_RST = DRV_HIZ;

    typedef enum logic [2:0] {
        ROLE_IDLE = 3'b000,
        ROLE_GPIO = 3'b001,
        ROLE_COMM = 3'b010,
        ROLE_ADC  = 3'b011,
        ROLE_ATX  = 3'b100
    } hpmg_role_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic       we;
        logic [3:0] pin;
        logic       gpio_en;
        logic       out_en;
        logic [6:0] duty;
        hpmg_drv_t  drv;
    } hpmg_cfg_t;

    typedef struct packed {
        logic we;
        logic ser_en;
        logic i2c_en;
        logic spi_en;
        logic atx_en;
    } hpmg_ifc_t;

    typedef struct packed {
        logic             valid;
        logic             ch;
        logic [ADC_W-1:0] code;
    } hpmg_smp_t;

    typedef struct packed {
        logic             valid;
        logic             ch;
        logic [QUO_W-1:0] avg16;
        logic [ADC_W-1:0] min;
        logic [ADC_W-1:0] max;
    } hpmg_ans_t;

    typedef struct packed {
        logic [NPIN-1:0]             gpio_en;
        logic [NPIN-1:0]             out_en;
        logic [NPIN-1:0][6:0]        duty;
        hpmg_drv_t [NPIN-1:0]        drv;
        logic                        ser_en;
        logic                        i2c_en;
        logic                        spi_en;
        logic                        atx_en;
        logic [CW-1:0]               pwm_pre;
        logic [CW-1:0]               poll_cnt;
        logic [CW-1:0]               adc_cnt;
        logic [6:0]                  pwm_ph;
        logic                        adc_start;
        logic [NPIN-1:0]             level;
        logic [NPIN-1:0]             pin_out;
        logic [NPIN-1:0]             pin_oe;
        logic [NPIN-1:0]             pad_pu;
        logic [NPIN-1:0]             pad_pd;
        logic [NPIN-1:0]             comm_in;
        logic                        power_sense;
        logic [1:0][SUM_W-1:0]       sum;
        logic [1:0][CNT_W-1:0]       cnt;
        logic [1:0][ADC_W-1:0]       mn;
        logic [1:0][ADC_W-1:0]       mx;
        logic                        busy;
        logic [5:0]                  itr;
        logic [NUM_W-1:0]            num;
        logic [CNT_W-1:0]            den;
        logic [CNT_W:0]              rem;
        logic [QUO_W-1:0]            quo;
        hpmg_ans_t                   ans;
    } hpmg_state_t;

endpackage

// file: hpmg_top.sv
// Expansion header pin mux with GPIO, PWM, 50 Hz input polling and ADC statistics.
// Protocol cores, ATX sequencer and ADC converter sit outside; pads resolve oe/pull.
//
// Operation
// - Thirteen header pins configure independently as GPIO or their special function.
// - Pins not claimed by an enabled interface may be GPIO input or output.
// - GPIO output drives constant high, constant low, or 100 Hz PWM.
// - GPIO inputs sampled at 50 Hz; last sample is reported.
// - GPIO drive mode: strong up, strong down, pull-up, pull-down, high impedance.
// - Pull-up input with switch to ground reads 1 open, 0 closed.
// - Enabled communication interface overrides GPIO configuration of its pins.
// - Serial on pins one and two enabled after reset; host must disable it.
// - Pins five and six default to analog inputs sampled at 11 kHz.
// - Average of samples since last read is reported times 16.
// - Minimum and maximum since last read are reported with the average.
// - Samples are 12-bit codes; average carries four extra fraction bits.
// - SPI enabled: pin twelve is data-ready, pins seven to ten carry SPI.
// - I2C enabled: pin thirteen is data-ready, pins three and four carry I2C.
`timescale 1ns/100ps
`default_nettype none

module hpmg_top #(
    parameter int PWM_CYC = hpmg_pkg::PWM_STEP_CYC,
    parameter int POL_CYC = hpmg_pkg::POLL_CYC,
    parameter int SMP_CYC = hpmg_pkg::ADC_CYC
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // Host commands
    input  wire hpmg_pkg::hpmg_cfg_t         cfg,
    input  wire hpmg_pkg::hpmg_ifc_t         ifc,
    input  wire logic                        adc_rd,
    input  wire logic                        adc_rd_ch,
    output logic [hpmg_pkg::NPIN-1:0]        gpio_level,
    output hpmg_pkg::hpmg_ans_t              adc_ans,
    // Header pads
    input  wire logic [hpmg_pkg::NPIN-1:0]   pin_in,
    output logic [hpmg_pkg::NPIN-1:0]        pin_out,
    output logic [hpmg_pkg::NPIN-1:0]        pin_oe,
    output logic [hpmg_pkg::NPIN-1:0]        pad_pu,
    output logic [hpmg_pkg::NPIN-1:0]        pad_pd,
    // Protocol cores
    input  wire logic [hpmg_pkg::NPIN-1:0]   comm_out,
    input  wire logic [hpmg_pkg::NPIN-1:0]   comm_oe,
    output logic [hpmg_pkg::NPIN-1:0]        comm_in,
    // ATX sequencer
    input  wire logic                        host_power_switch_drive_out,
    input  wire logic                        host_power_switch_drive_oe,
    input  wire logic                        host_restart_drive_out,
    input  wire logic                        host_restart_drive_oe,
    output logic                             power_sense,
    // Converter
    output logic                             adc_start,
    input  wire hpmg_pkg::hpmg_smp_t         adc_smp
);
    import hpmg_pkg::*;

    hpmg_state_t s_r;
    hpmg_state_t s_nxt;

    function automatic hpmg_role_t pin_role(input int i, input hpmg_state_t s);
        if ((s.ser_en && SER_MASK[i]) || (s.i2c_en && I2C_MASK[i]) ||
            (s.spi_en && SPI_MASK[i]))
            return ROLE_COMM;
        if (s.gpio_en[i])
            return ROLE_GPIO;
        if (ADC_MASK[i])
            return ROLE_ADC;
        if (s.atx_en && ATX_MASK[i])
            return ROLE_ATX;
        return ROLE_IDLE;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        hpmg_state_t n;
        hpmg_role_t  role;
        logic        lvl;
        logic        pwm_tick;
        logic        poll_tick;
        logic [CNT_W:0] rem_t;
        int          c;
        n = s_r;
        role = ROLE_IDLE;
        lvl = 1'b0;
        rem_t = '0;
        c = 0;
        n.ans.valid = 1'b0;
        n.adc_start = 1'b0;
        pwm_tick = (s_r.pwm_pre == '0);
        poll_tick = (s_r.poll_cnt == '0);
        // Host configuration
        if (cfg.we && (int'(cfg.pin) < NPIN)) begin
            n.gpio_en[cfg.pin] = cfg.gpio_en;
            n.out_en[cfg.pin] = cfg.out_en;
            n.duty[cfg.pin] = (cfg.duty > DUTY_FULL) ? DUTY_FULL : cfg.duty;
            n.drv[cfg.pin] = cfg.drv;
        end
        if (ifc.we) begin
            n.ser_en = ifc.ser_en;
            n.i2c_en = ifc.i2c_en;
            n.spi_en = ifc.spi_en;
            n.atx_en = ifc.atx_en;
        end
        // Timebases
        n.pwm_pre = pwm_tick ? CW'(PWM_CYC - 1) : s_r.pwm_pre - CW'(1);
        if (pwm_tick)
            n.pwm_ph = (s_r.pwm_ph == PH_LAST) ? '0 : s_r.pwm_ph + 7'h01;
        n.poll_cnt = poll_tick ? CW'(POL_CYC - 1) : s_r.poll_cnt - CW'(1);
        if (s_r.adc_cnt == '0) begin
            n.adc_cnt = CW'(SMP_CYC - 1);
            n.adc_start = (pin_role(P_ADC0, s_r) == ROLE_ADC) ||
                          (pin_role(P_ADC0 + 1, s_r) == ROLE_ADC);
        end else begin
            n.adc_cnt = s_r.adc_cnt - CW'(1);
        end
        // Pad drive per pin
        for (int i = 0; i < NPIN; i++) begin
            role = pin_role(i, s_r);
            lvl = (s_r.duty[i] > s_r.pwm_ph);
            n.pin_out[i] = 1'b0;
            n.pin_oe[i] = 1'b0;
            n.pad_pu[i] = 1'b0;
            n.pad_pd[i] = 1'b0;
            unique case (role)
                ROLE_COMM: begin
                    n.pin_out[i] = comm_out[i];
                    n.pin_oe[i] = comm_oe[i];
                end
                ROLE_ATX: begin
                    n.pin_out[i] = (i == P_PWR_CTL) ? host_power_switch_drive_out
                                                    : host_restart_drive_out;
                    n.pin_oe[i] = (i == P_PWR_CTL) ? host_power_switch_drive_oe
                                                   : host_restart_drive_oe;
                end
                ROLE_GPIO: begin
                    n.pad_pu[i] = (s_r.drv[i] == DRV_PULL_UP);
                    n.pad_pd[i] = (s_r.drv[i] == DRV_PULL_DOWN);
                    if (s_r.out_en[i]) begin
                        n.pin_out[i] = lvl;
                        n.pin_oe[i] = (s_r.drv[i] == DRV_STRONG) ||
                                      (s_r.drv[i] == DRV_STRONG_UP && lvl) ||
                                      (s_r.drv[i] == DRV_STRONG_DOWN && !lvl);
                    end else if (poll_tick) begin
                        n.level[i] = pin_in[i];
                    end
                end
                ROLE_ADC, ROLE_IDLE: begin
                end
            endcase
        end
        n.comm_in = pin_in;
        n.power_sense = pin_in[P_PWR_SNS];
        // Analog query: snapshot and clear, then accumulate
        if (adc_rd && !s_r.busy) begin
            c = int'(adc_rd_ch);
            n.busy = 1'b1;
            n.itr = '0;
            n.num = NUM_W'({s_r.sum[c], AVG_PAD});
            n.den = s_r.cnt[c];
            n.rem = '0;
            n.quo = '0;
            n.ans.ch = adc_rd_ch;
            n.ans.min = (s_r.cnt[c] == '0) ? '0 : s_r.mn[c];
            n.ans.max = s_r.mx[c];
            n.sum[c] = '0;
            n.cnt[c] = '0;
            n.mn[c] = MIN_INIT;
            n.mx[c] = '0;
        end
        c = int'(adc_smp.ch);
        if (adc_smp.valid && pin_role(P_ADC0 + c, s_r) == ROLE_ADC &&
            n.cnt[c] != '1) begin
            n.sum[c] = n.sum[c] + SUM_W'(adc_smp.code);
            n.cnt[c] = n.cnt[c] + CNT_W'(1);
            if (adc_smp.code < n.mn[c])
                n.mn[c] = adc_smp.code;
            if (adc_smp.code > n.mx[c])
                n.mx[c] = adc_smp.code;
        end
        // Restoring divider, one quotient bit per cycle
        if (s_r.busy) begin
            rem_t = {s_r.rem[CNT_W-1:0], s_r.num[NUM_W-1]};
            n.num = {s_r.num[NUM_W-2:0], 1'b0};
            if (rem_t >= {1'b0, s_r.den}) begin
                n.rem = rem_t - {1'b0, s_r.den};
                n.quo = {s_r.quo[QUO_W-2:0], 1'b1};
            end else begin
                n.rem = rem_t;
                n.quo = {s_r.quo[QUO_W-2:0], 1'b0};
            end
            n.itr = s_r.itr + 6'h01;
            if (s_r.itr == DIV_LAST) begin
                n.busy = 1'b0;
                n.ans.valid = 1'b1;
                n.ans.avg16 = (s_r.den == '0) ? '0 : n.quo;
            end
        end
        if (rst) begin
            n = '0;
            n.ser_en = SER_EN_RST;
            n.i2c_en = I2C_EN_RST;
            n.spi_en = SPI_EN_RST;
            n.atx_en = ATX_EN_RST;
            for (int i = 0; i < NPIN; i++) begin
                n.drv[i] = DRV_RST;
            end
            n.mn = {2{MIN_INIT}};
        end
        s_nxt = n;
    end

    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    assign gpio_level = s_r.level;
    assign adc_ans = s_r.ans;
    assign pin_out = s_r.pin_out;
    assign pin_oe = s_r.pin_oe;
    assign pad_pu = s_r.pad_pu;
    assign pad_pd = s_r.pad_pd;
    assign comm_in = s_r.comm_in;
    assign power_sense = s_r.power_sense;
    assign adc_start = s_r.adc_start;

    // ==========================================================
    // Checks
    a_serial_priority: assert property (
        @(posedge clk) disable iff (rst)
        s_r.ser_en && !ifc.we |=> pin_oe[1] == $past(comm_oe[1]) && pin_out[1] == $past(comm_out[1]))
        else $error("serial pin not handed to serial core");
    a_serial_default: assert property (
        @(posedge clk) $past(rst) && !rst |-> s_r.ser_en && !s_r.spi_en && !s_r.i2c_en)
        else $error("interface enables wrong after reset");
    a_duty_full: assert property (
        @(posedge clk) disable iff (rst)
        s_r.gpio_en[10] && s_r.out_en[10] && s_r.duty[10] == DUTY_FULL && !cfg.we
        |=> pin_out[10] [*2])
        else $error("full duty did not hold high");
    a_duty_zero: assert property (
        @(posedge clk) disable iff (rst)
        s_r.gpio_en[10] && s_r.out_en[10] && s_r.duty[10] == '0 |=> !pin_out[10])
        else $error("zero duty drove high");
    a_poll_level: assert property (
        @(posedge clk) disable iff (rst)
        !$stable(gpio_level) |-> $past(s_r.poll_cnt) == '0)
        else $error("input level changed off the poll tick");
    a_pull_up_in: assert property (
        @(posedge clk) disable iff (rst)
        pin_role(10, s_r) == ROLE_GPIO && !s_r.out_en[10] && s_r.drv[10] == DRV_PULL_UP
        |=> pad_pu[10] && !pin_oe[10])
        else $error("pull-up input not pulled");
    a_spi_ready: assert property (
        @(posedge clk) disable iff (rst)
        s_r.spi_en && !ifc.we |=> pin_oe[11] == $past(comm_oe[11]))
        else $error("spi data-ready pin not driven by core");
    a_i2c_ready: assert property (
        @(posedge clk) disable iff (rst)
        s_r.i2c_en && !ifc.we |=> pin_oe[12] == $past(comm_oe[12]))
        else $error("i2c data-ready pin not driven by core");
    a_query_clear: assert property (
        @(posedge clk) disable iff (rst)
        adc_rd && !s_r.busy |=> s_r.cnt[$past(adc_rd_ch)] <= CNT_W'(1))
        else $error("statistics not cleared after query");
    a_answer_time: assert property (
        @(posedge clk) disable iff (rst)
        adc_rd && !s_r.busy |-> ##37 adc_ans.valid)
        else $error("average answer not 37 cycles after query");
    a_min_le_max: assert property (
        @(posedge clk) disable iff (rst)
        adc_ans.valid |-> adc_ans.min <= adc_ans.max)
        else $error("reported minimum above maximum");

    // ==========================================================
    // Checks on answer timing, pin hand-over, idle pins and converter start
    a_answer_early: assert property (
        @(posedge clk) disable iff (rst)
        s_r.busy |-> !adc_ans.valid)
        else $error("average answer came early");
    a_comm_copy: assert property (
        @(posedge clk) disable iff (rst)
        !rst |=> comm_in == $past(pin_in))
        else $error("pin levels not passed to cores");
    a_power_sense: assert property (
        @(posedge clk) disable iff (rst)
        !rst |=> power_sense == $past(pin_in[P_PWR_SNS]))
        else $error("power sense not copied");
    a_idle_quiet: assert property (
        @(posedge clk) disable iff (rst)
        pin_role(10, s_r) == ROLE_IDLE |=> !pin_oe[10] && !pad_pu[10] && !pad_pd[10])
        else $error("idle pin driven or pulled");
    a_atx_power: assert property (
        @(posedge clk) disable iff (rst)
        pin_role(P_PWR_CTL, s_r) == ROLE_ATX
        |=> pin_oe[P_PWR_CTL] == $past(host_power_switch_drive_oe))
        else $error("power control pin not handed to sequencer");
    a_atx_restart: assert property (
        @(posedge clk) disable iff (rst)
        pin_role(P_RESTART, s_r) == ROLE_ATX
        |=> pin_oe[P_RESTART] == $past(host_restart_drive_oe))
        else $error("restart pin not handed to sequencer");
    a_adc_start: assert property (
        @(posedge clk) disable iff (rst)
        s_r.adc_cnt == '0 && pin_role(P_ADC0, s_r) == ROLE_ADC |=> adc_start)
        else $error("converter start missing");

endmodule // hpmg_top

`default_nettype wire

// file: hpmg_pad_model.sv
// Far side of the header: switches to ground, pad pulls, floating pins and a two-channel ADC.
// Assumes the pin mux drives pad controls and the converter start on the rising clock edge.
`timescale 1ns/100ps
`default_nettype none

module hpmg_pad_model (
    // Clock
    input  wire logic                      clk,
    // Pads
    input  wire logic [hpmg_pkg::NPIN-1:0] pin_out,
    input  wire logic [hpmg_pkg::NPIN-1:0] pin_oe,
    input  wire logic [hpmg_pkg::NPIN-1:0] pad_pu,
    input  wire logic [hpmg_pkg::NPIN-1:0] pad_pd,
    input  wire logic [hpmg_pkg::NPIN-1:0] sw_closed,
    output logic [hpmg_pkg::NPIN-1:0]      pin_in,
    // Converter
    input  wire logic                      adc_start,
    output hpmg_pkg::hpmg_smp_t            adc_smp
);
    import hpmg_pkg::*;
    logic [NPIN-1:0] flt;
    logic [1:0]      phase;

    initial begin
        flt     = 13'h0aaa;
        phase   = 2'h0;
        adc_smp = '0;
    end

    // Undriven, unpulled pins wander every cycle
    always @(posedge clk) begin
        flt <= ~flt;
    end

    // ==========================================================
    // Pad resolution: driver beats switch, switch beats pull
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (sw_closed[i]) pin_in[i] = 1'b0;
            else if (pad_pu[i]) pin_in[i] = 1'b1;
            else if (pad_pd[i]) pin_in[i] = 1'b0;
            else pin_in[i] = flt[i];
        end
    end

    // ==========================================================
    // Converter: each start yields a channel 0 then a channel 1 sample
    always @(posedge clk) begin
        phase         <= {phase[0], adc_start};
        adc_smp.valid <= phase[0] | phase[1];
        adc_smp.ch    <= phase[1];
        if (phase[0] | phase[1]) adc_smp.code <= 12'($urandom);
        else adc_smp.code <= ~adc_smp.code;
    end
endmodule // hpmg_pad_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the header pin mux with shortened PWM, poll and sample counts.
// Assumes hpmg_pkg, hpmg_top and hpmg_pad_model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import hpmg_pkg::*;
    localparam int PWM_CYC = 4;
    localparam int POL_CYC = 50;
    localparam int SMP_CYC = 20;
    logic clk, rst, adc_rd, adc_rd_ch, adc_start, power_sense;
    logic psw_out, psw_oe, rsd_out, rsd_oe;
    hpmg_cfg_t cfg;
    hpmg_ifc_t ifc;
    hpmg_ans_t adc_ans;
    hpmg_smp_t adc_smp;
    logic [NPIN-1:0] gpio_level, pin_in, pin_out, pin_oe, pad_pu, pad_pd;
    logic [NPIN-1:0] comm_out, comm_oe, comm_in, sw_closed, m, pin_in_q;
    int n_errors, n_compared, ci, s_cnt, s_mn, s_mx;
    int r_cnt [2], r_mn [2], r_mx [2];
    longint r_sum [2], s_sum;

    hpmg_top #(.PWM_CYC(PWM_CYC), .POL_CYC(POL_CYC), .SMP_CYC(SMP_CYC)) hpmg_top_inst (
        .clk(clk), .rst(rst), .cfg(cfg), .ifc(ifc), .adc_rd(adc_rd), .adc_rd_ch(adc_rd_ch),
        .gpio_level(gpio_level), .adc_ans(adc_ans), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pad_pu(pad_pu), .pad_pd(pad_pd), .comm_out(comm_out),
        .comm_oe(comm_oe), .comm_in(comm_in), .host_power_switch_drive_out(psw_out),
        .host_power_switch_drive_oe(psw_oe), .host_restart_drive_out(rsd_out),
        .host_restart_drive_oe(rsd_oe), .power_sense(power_sense), .adc_start(adc_start),
        .adc_smp(adc_smp));

    hpmg_pad_model hpmg_pad_model_inst (
        .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pad_pu(pad_pu), .pad_pd(pad_pd),
        .sw_closed(sw_closed), .pin_in(pin_in), .adc_start(adc_start), .adc_smp(adc_smp));

    always #2 clk = ~clk;

    always @(posedge clk) pin_in_q <= pin_in;

    // ==========================================================
    // Reference statistics, snapshot on the query edge
    always @(posedge clk) begin
        if (rst) begin
            r_cnt = '{0, 0};
            r_sum = '{0, 0};
        end else begin
            if (adc_rd) begin
                ci = adc_rd_ch;
                {s_sum, s_cnt, s_mn, s_mx} = {r_sum[ci], r_cnt[ci], r_mn[ci], r_mx[ci]};
                r_sum[ci] = 0;
                r_cnt[ci] = 0;
            end
            if (adc_smp.valid) begin
                ci = adc_smp.ch;
                if (r_cnt[ci] == 0 || adc_smp.code < r_mn[ci]) r_mn[ci] = adc_smp.code;
                if (r_cnt[ci] == 0 || adc_smp.code > r_mx[ci]) r_mx[ci] = adc_smp.code;
                r_sum[ci] += adc_smp.code;
                r_cnt[ci]++;
            end
        end
    end

    // ==========================================================
    // Helpers
    function automatic logic [2:0] exp_pad(input int md, input logic om, input logic lv);
        exp_pad[2] = om && (md == DRV_STRONG || (md == DRV_STRONG_UP && lv)
                     || (md == DRV_STRONG_DOWN && !lv));
        exp_pad[1] = (md == DRV_PULL_UP);
        exp_pad[0] = (md == DRV_PULL_DOWN);
    endfunction

    task automatic report_and_stop();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic set_pin(input int p, input logic ge, om, input logic [6:0] d, input int md);
        @(posedge clk);
        cfg <= '{1'b1, 4'(p), ge, om, d, hpmg_drv_t'(md)};
        @(posedge clk);
        cfg.we <= 1'b0;
        tick(3);
    endtask

    task automatic set_ifc(input logic [3:0] en);
        @(posedge clk);
        ifc <= {1'b1, en};
        @(posedge clk);
        ifc.we <= 1'b0;
        tick(3);
    endtask

    task automatic rand_drv();
        @(posedge clk);
        comm_out <= 13'($urandom);
        comm_oe  <= 13'($urandom);
        {psw_out, psw_oe, rsd_out, rsd_oe} <= 4'($urandom);
        tick(3);
    endtask

    task automatic query(input logic ch);
        int k;
        @(posedge clk);
        adc_rd    <= 1'b1;
        adc_rd_ch <= ch;
        @(posedge clk);
        adc_rd <= 1'b0;
        for (k = 2; k < 61; k++) begin
            tick(1);
            if (adc_ans.valid === 1'b1) break;
        end
        if (k == 61) begin
            n_errors++;
            report_and_stop();
        end
        chk("answer latency", 37, k);
        chk("answer ch", ch, adc_ans.ch);
        chk("avg16", s_cnt ? (s_sum * 16) / s_cnt : 0, adc_ans.avg16);
        chk("min", s_cnt ? s_mn : 0, adc_ans.min);
        chk("max", s_cnt ? s_mx : 0, adc_ans.max);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        int d, hi;
        void'($urandom(77919));
        {clk, adc_rd, adc_rd_ch, psw_out, psw_oe, rsd_out, rsd_oe} = '0;
        {cfg, ifc, comm_out, comm_oe, sw_closed} = '0;
        n_errors = 0;
        n_compared = 0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("reset ans", 0, adc_ans);
        chk("reset pulls", 0, {pad_pu, pad_pd});
        chk("reset oe", 0, pin_oe);
        // Serial owns pins 1 and 2 until disabled; GPIO setup waits behind it
        rand_drv();
        set_pin(0, 1'b1, 1'b1, DUTY_FULL, DRV_STRONG);
        chk("serial oe", comm_oe[1:0], pin_oe[1:0]);
        chk("serial out", comm_out[1:0] & comm_oe[1:0], pin_out[1:0] & comm_oe[1:0]);
        set_ifc(4'b0001);
        chk("serial off", 3'b010, {pin_oe[1:0] & pin_out[1:0], pin_oe[1]});
        // I2C and SPI claim their pins; SPI takes pins 9 and 10 over power control
        for (int r = 0; r < 4; r++) begin
            rand_drv();
            set_ifc(4'b0111);
            m = I2C_MASK | SPI_MASK;
            chk("comm oe", comm_oe & m, pin_oe & m);
            chk("comm out", comm_out & comm_oe & m, pin_out & comm_oe & m);
            chk("comm in", pin_in_q, comm_in);
            chk("power sense", pin_in_q[P_PWR_SNS], power_sense);
            set_ifc(4'b0001);
            chk("power ctl", {rsd_oe, psw_oe}, pin_oe[9:8]);
        end
        // Drive modes on a plain pin, constant levels via duty 0 and 100
        for (int md = 0; md < 6; md++) begin
            for (int om = 0; om < 2; om++) begin
                for (int lv = 0; lv < 2; lv++) begin
                    set_pin(10, 1'b1, om[0], lv ? DUTY_FULL : 7'h00, md);
                    chk("pad ctl", exp_pad(md, om[0], lv[0]), {pin_oe[10], pad_pu[10], pad_pd[10]});
                    if (om) chk("pad level", lv, pin_out[10]);
                end
            end
        end
        // PWM: any full period holds duty steps of high level
        for (int r = 0; r < 3; r++) begin
            d = (r == 0) ? 1 : (r == 1) ? 99 : 1 + $urandom % 99;
            set_pin(10, 1'b1, 1'b1, 7'(d), DRV_STRONG);
            hi = 0;
            repeat (100 * PWM_CYC) begin
                tick(1);
                hi += pin_out[10];
            end
            chk("pwm highs", d * PWM_CYC, hi);
        end
        // Polled input with pulls and a switch to ground
        set_pin(6, 1'b1, 1'b0, 7'h00, DRV_PULL_UP);
        tick(POL_CYC + 6);
        chk("open switch", 1'b1, gpio_level[6]);
        sw_closed[6] <= 1'b1;
        tick(POL_CYC + 6);
        chk("closed switch", 1'b0, gpio_level[6]);
        sw_closed[6] <= 1'b0;
        set_pin(6, 1'b1, 1'b0, 7'h00, DRV_PULL_DOWN);
        tick(POL_CYC + 6);
        chk("pull down", 1'b0, gpio_level[6]);
        // Converter start rate, then statistics per read interval
        hi = 0;
        repeat (10 * SMP_CYC) begin
            tick(1);
            hi += adc_start;
        end
        chk("start pulses", 10, hi);
        tick(300);
        query(1'b0);
        query(1'b1);
        query(1'b0);
        tick(150);
        query(1'b1);
        report_and_stop();
    end

    initial begin
        #400000;
        n_errors++;
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
